/* File: inc/scu_pkg.sv */
package scu_pkg;
	// Register byte offsets on the APB port
	localparam logic [7:0] SCU_MODE_OFF = 8'h00;
	localparam logic [7:0] SCU_CTL0_OFF = 8'h04;
	localparam logic [7:0] SCU_CTL1_OFF = 8'h08;
	localparam logic [7:0] SCU_BRG_OFF = 8'h0c;
	localparam logic [7:0] SCU_TXB_OFF = 8'h10;
	localparam logic [7:0] SCU_RXB_OFF = 8'h14;
	localparam logic [7:0] SCU_STAT_OFF = 8'h18;
	// Values after reset
	localparam logic [7:0] SCU_MODE_RST = 8'h00;
	localparam logic [7:0] SCU_CTL0_RST = 8'h00;
	localparam logic [7:0] SCU_CTL1_RST = 8'h02;
	localparam logic [7:0] SCU_BRG_RST = 8'h00;
	// Operating mode code of the 8-bit asynchronous frame
	localparam logic [2:0] SCU_UART8 = 3'h5;
	// Prescaler select codes
	localparam logic [1:0] SCU_SEL_F1 = 2'h0;
	localparam logic [1:0] SCU_SEL_F8 = 2'h1;
	// Sixteen oversampling ticks per bit
	localparam logic [3:0] SCU_OVS_LAST = 4'hf;
	localparam logic [3:0] SCU_OVS_MID = 4'h7;
	localparam logic [2:0] SCU_BIT_LAST = 3'h7;
	localparam logic [2:0] SCU_DIV8_LAST = 3'h7;
	localparam logic [4:0] SCU_DIV32_LAST = 5'h1f;
	// Receive buffer read field positions
	localparam int SCU_RXB_OVR = 12;
	localparam int SCU_RXB_FE = 13;
	localparam int SCU_RXB_PE = 14;
	localparam int SCU_RXB_SUM = 15;

	typedef struct packed {
		logic sleep;
		logic par_en;
		logic par_even;
		logic two_stop;
		logic ext_clk;
		logic [2:0] smode;
	} scu_mode_t;

	typedef struct packed {
		logic msb_first;
		logic rsv6;
		logic open_drain;
		logic flow_off;
		logic [1:0] rsv;
		logic [1:0] clk_sel;
	} scu_ctl0_t;

	typedef struct packed {
		logic err_en;
		logic data_inv;
		logic rsv5;
		logic irq_done;
		logic rx_full;
		logic re;
		logic tx_empty;
		logic te;
	} scu_ctl1_t;

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [7:0] paddr;
		logic [31:0] pwdata;
	} scu_apb_req_t;

	typedef struct packed {
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} scu_apb_rsp_t;

	typedef enum {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP, TX_GUARD} scu_tx_state_t;
	typedef enum {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP, RX_ERRSIG} scu_rx_state_t;
endpackage : scu_pkg

/* File: hw/scu_sim_uart.sv */
// Design decisions made here: the register offsets and the APB slave port.
`timescale 1ns/1ps
module scu_sim_uart (
	// Clock and reset
	input wire logic clock,
	input wire logic sys_rst,
	// APB register port
	input scu_pkg::scu_apb_req_t apb_req,
	output scu_pkg::scu_apb_rsp_t apb_rsp,
	// Serial line, clear-to-send and clock pins
	input wire logic serial_in_pin,
	input wire logic channel_clock_pin,
	input wire logic cts_in_n,
	output logic serial_out_pin,
	output logic serial_out_oe
);
	import scu_pkg::*;

	// Baud generation state
	logic [4:0] pre_cnt_reg, pre_cnt_next;
	logic [7:0] brg_cnt_reg, brg_cnt_next;
	logic ext_prev_reg, ovs_reg, ovs_next, src_tick;

	// Registers and engine state
	scu_mode_t mode_reg, mode_next;
	scu_ctl0_t ctl0_reg, ctl0_next;
	scu_ctl1_t ctl1_reg, ctl1_next;
	scu_apb_rsp_t rsp_reg, rsp_next;
	logic [7:0] brg_reg, brg_next, txbuf_reg, txbuf_next, rxbuf_reg, rxbuf_next;
	logic ovr_reg, ovr_next, fe_reg, fe_next, pe_reg, pe_next;
	logic tx_req_reg, tx_req_next, rx_req_reg, rx_req_next, lvl_reg, lvl_next;
	scu_tx_state_t tx_state_reg, tx_state_next;
	scu_rx_state_t rx_state_reg, rx_state_next;
	logic [3:0] tx_cnt_reg, tx_cnt_next, rx_cnt_reg, rx_cnt_next;
	logic [2:0] tx_bit_reg, tx_bit_next, rx_bit_reg, rx_bit_next;
	logic [7:0] tx_sh_reg, tx_sh_next, rx_sh_reg, rx_sh_next;
	logic tx_par_reg, tx_par_next, rx_par_reg, rx_par_next;
	logic rx_pe_reg, rx_pe_next, rx_phase_reg, rx_phase_next;
	logic out_reg, out_next, oe_reg, oe_next;
	logic card_ok, acc, done, hit, tx_level, line_level, rx_done;
	logic [7:0] rx_view;

	assign apb_rsp = rsp_reg;
	assign serial_out_pin = out_reg;
	assign serial_out_oe = oe_reg;

	always_comb begin
		pre_cnt_next = pre_cnt_reg + 5'h01;
		if (mode_reg.ext_clk)
			src_tick = channel_clock_pin & ~ext_prev_reg;
		else begin
			case (ctl0_reg.clk_sel)
				SCU_SEL_F1: src_tick = 1'b1;
				SCU_SEL_F8: src_tick = (pre_cnt_reg[2:0] == SCU_DIV8_LAST);
				default: src_tick = (pre_cnt_reg == SCU_DIV32_LAST);
			endcase
		end
		brg_cnt_next = brg_cnt_reg;
		ovs_next = 1'b0;
		if (src_tick) begin
			if (brg_cnt_reg == 8'h00) begin
				brg_cnt_next = brg_reg;
				ovs_next = 1'b1;
			end else
				brg_cnt_next = brg_cnt_reg - 8'h01;
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			pre_cnt_reg <= 5'h00;
			brg_cnt_reg <= 8'h00;
			ext_prev_reg <= 1'b0;
			ovs_reg <= 1'b0;
		end else begin
			pre_cnt_reg <= pre_cnt_next;
			brg_cnt_reg <= brg_cnt_next;
			ext_prev_reg <= channel_clock_pin;
			ovs_reg <= ovs_next;
		end
	end

	assign card_ok = (mode_reg.smode == SCU_UART8) && !mode_reg.two_stop;
	assign acc = apb_req.psel & apb_req.penable;
	assign done = acc & rsp_reg.pready;
	assign hit = (apb_req.paddr[1:0] == 2'h0) && (apb_req.paddr <= SCU_STAT_OFF);
	assign rx_view = ctl1_reg.data_inv ? ~rxbuf_reg : rxbuf_reg;
	assign rx_done = (rx_state_reg == RX_STOP) && ovs_reg && (rx_cnt_reg == SCU_OVS_MID);

	always_comb begin
		case (tx_state_reg)
			TX_START: tx_level = 1'b0;
			TX_DATA: tx_level = ctl0_reg.msb_first ? tx_sh_reg[7] : tx_sh_reg[0];
			TX_PAR: tx_level = mode_reg.par_even ? tx_par_reg : ~tx_par_reg;
			default: tx_level = 1'b1;
		endcase
		line_level = tx_level & ~((rx_state_reg == RX_ERRSIG) && rx_phase_reg);
	end

	always_comb begin
		mode_next = mode_reg;
		ctl0_next = ctl0_reg;
		ctl1_next = ctl1_reg;
		brg_next = brg_reg;
		txbuf_next = txbuf_reg;
		rxbuf_next = rxbuf_reg;
		ovr_next = ovr_reg;
		fe_next = fe_reg;
		pe_next = pe_reg;
		tx_req_next = tx_req_reg;
		rx_req_next = rx_req_reg;
		lvl_next = lvl_reg;
		tx_state_next = tx_state_reg;
		rx_state_next = rx_state_reg;
		tx_cnt_next = tx_cnt_reg;
		rx_cnt_next = rx_cnt_reg;
		tx_bit_next = tx_bit_reg;
		rx_bit_next = rx_bit_reg;
		tx_sh_next = tx_sh_reg;
		rx_sh_next = rx_sh_reg;
		tx_par_next = tx_par_reg;
		rx_par_next = rx_par_reg;
		rx_pe_next = rx_pe_reg;
		rx_phase_next = rx_phase_reg;
		rsp_next = '0;
		// APB: one wait cycle, then pready with data
		rsp_next.pready = acc & ~rsp_reg.pready;
		rsp_next.pslverr = acc & ~rsp_reg.pready & ~hit;
		if (acc && !rsp_reg.pready && !apb_req.pwrite) begin
			case (apb_req.paddr)
				SCU_MODE_OFF: rsp_next.prdata = {24'h0, mode_reg};
				SCU_CTL0_OFF: rsp_next.prdata = {24'h0, ctl0_reg};
				SCU_CTL1_OFF: rsp_next.prdata = {24'h0, ctl1_reg};
				SCU_BRG_OFF: rsp_next.prdata = {24'h0, brg_reg};
				SCU_RXB_OFF: rsp_next.prdata = {16'h0, ovr_reg | fe_reg | pe_reg, pe_reg,
					fe_reg, ovr_reg, 4'h0, rx_view};
				SCU_STAT_OFF: rsp_next.prdata = {28'h0, tx_state_reg != TX_IDLE, lvl_reg,
					rx_req_reg, tx_req_reg};
				default: rsp_next.prdata = 32'h0;
			endcase
		end
		if (done && hit && apb_req.pwrite) begin
			case (apb_req.paddr)
				SCU_MODE_OFF: begin
					mode_next = apb_req.pwdata[7:0];
					mode_next.sleep = 1'b0;
				end
				SCU_CTL0_OFF: ctl0_next = apb_req.pwdata[7:0];
				SCU_CTL1_OFF: begin
					ctl1_next = apb_req.pwdata[7:0];
					ctl1_next.tx_empty = ctl1_reg.tx_empty;
					ctl1_next.rx_full = ctl1_reg.rx_full;
				end
				SCU_BRG_OFF: brg_next = apb_req.pwdata[7:0];
				SCU_TXB_OFF: begin
					txbuf_next = ctl1_reg.data_inv ? ~apb_req.pwdata[7:0] : apb_req.pwdata[7:0];
					ctl1_next.tx_empty = 1'b0;
				end
				SCU_STAT_OFF: begin
					if (apb_req.pwdata[0])
						tx_req_next = 1'b0;
					if (apb_req.pwdata[1])
						rx_req_next = 1'b0;
				end
				default: ;
			endcase
		end
		if (done && !apb_req.pwrite && apb_req.paddr == SCU_RXB_OFF) begin
			ctl1_next.rx_full = 1'b0;
			ovr_next = 1'b0;
		end
		// Transmitter
		if (ovs_reg && tx_state_reg != TX_IDLE)
			tx_cnt_next = tx_cnt_reg + 4'h1;
		case (tx_state_reg)
			TX_IDLE: begin
				if (card_ok && ctl1_reg.te && !ctl1_reg.tx_empty
					&& (ctl0_reg.flow_off || !cts_in_n)) begin
					tx_sh_next = txbuf_reg;
					ctl1_next.tx_empty = 1'b1;
					tx_par_next = 1'b0;
					tx_bit_next = 3'h0;
					tx_cnt_next = 4'h0;
					tx_state_next = TX_START;
					if (!ctl1_reg.irq_done)
						tx_req_next = 1'b1;
				end
			end
			TX_START: begin
				if (ovs_reg && tx_cnt_reg == SCU_OVS_LAST)
					tx_state_next = TX_DATA;
			end
			TX_DATA: begin
				if (ovs_reg && tx_cnt_reg == SCU_OVS_LAST) begin
					tx_par_next = tx_par_reg ^ tx_level;
					tx_sh_next = ctl0_reg.msb_first ? {tx_sh_reg[6:0], 1'b0} : {1'b0, tx_sh_reg[7:1]};
					tx_bit_next = tx_bit_reg + 3'h1;
					if (tx_bit_reg == SCU_BIT_LAST)
						tx_state_next = mode_reg.par_en ? TX_PAR : TX_STOP;
				end
			end
			TX_PAR: begin
				if (ovs_reg && tx_cnt_reg == SCU_OVS_LAST)
					tx_state_next = TX_STOP;
			end
			TX_STOP: begin
				if (ovs_reg && tx_cnt_reg == SCU_OVS_LAST) begin
					if (ctl1_reg.err_en)
						tx_state_next = TX_GUARD;
					else begin
						tx_state_next = TX_IDLE;
						if (ctl1_reg.irq_done) begin
							tx_req_next = 1'b1;
							lvl_next = serial_in_pin;
						end
					end
				end
			end
			TX_GUARD: begin
				if (ovs_reg && tx_cnt_reg == SCU_OVS_MID && ctl1_reg.irq_done) begin
					tx_req_next = 1'b1;
					lvl_next = serial_in_pin;
				end
				if (ovs_reg && tx_cnt_reg == SCU_OVS_LAST)
					tx_state_next = TX_IDLE;
			end
			default: tx_state_next = TX_IDLE;
		endcase
		// Receiver
		if (ovs_reg && rx_state_reg != RX_IDLE)
			rx_cnt_next = rx_cnt_reg + 4'h1;
		case (rx_state_reg)
			RX_IDLE: begin
				if (card_ok && ctl1_reg.re && !serial_in_pin) begin
					rx_cnt_next = 4'h0;
					rx_bit_next = 3'h0;
					rx_par_next = 1'b0;
					rx_state_next = RX_START;
				end
			end
			RX_START: begin
				if (ovs_reg && rx_cnt_reg == SCU_OVS_MID && serial_in_pin)
					rx_state_next = RX_IDLE;
				else if (ovs_reg && rx_cnt_reg == SCU_OVS_LAST)
					rx_state_next = RX_DATA;
			end
			RX_DATA: begin
				if (ovs_reg && rx_cnt_reg == SCU_OVS_MID) begin
					rx_par_next = rx_par_reg ^ serial_in_pin;
					rx_sh_next = ctl0_reg.msb_first ? {rx_sh_reg[6:0], serial_in_pin}
						: {serial_in_pin, rx_sh_reg[7:1]};
				end
				if (ovs_reg && rx_cnt_reg == SCU_OVS_LAST) begin
					rx_bit_next = rx_bit_reg + 3'h1;
					rx_pe_next = 1'b0;
					if (rx_bit_reg == SCU_BIT_LAST)
						rx_state_next = mode_reg.par_en ? RX_PAR : RX_STOP;
				end
			end
			RX_PAR: begin
				if (ovs_reg && rx_cnt_reg == SCU_OVS_MID)
					rx_pe_next = mode_reg.par_even ? (rx_par_reg ^ serial_in_pin)
						: ~(rx_par_reg ^ serial_in_pin);
				if (ovs_reg && rx_cnt_reg == SCU_OVS_LAST)
					rx_state_next = RX_STOP;
			end
			RX_STOP: begin
				if (rx_done) begin
					rxbuf_next = rx_sh_reg;
					fe_next = ~serial_in_pin;
					pe_next = rx_pe_reg;
					ovr_next = ctl1_next.rx_full | ovr_next;
					if (!ctl1_next.rx_full)
						rx_req_next = 1'b1;
					ctl1_next.rx_full = 1'b1;
					rx_phase_next = 1'b0;
					rx_state_next = (rx_pe_reg && ctl1_reg.err_en) ? RX_ERRSIG : RX_IDLE;
				end
			end
			RX_ERRSIG: begin
				if (ovs_reg && rx_cnt_reg == SCU_OVS_LAST) begin
					rx_phase_next = ~rx_phase_reg;
					if (rx_phase_reg)
						rx_state_next = RX_IDLE;
				end
			end
			default: rx_state_next = RX_IDLE;
		endcase
		// Open-drain only pulls low
		out_next = ctl0_reg.open_drain ? 1'b0 : line_level;
		oe_next = ctl0_reg.open_drain ? ~line_level : 1'b1;
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			mode_reg <= SCU_MODE_RST;
			ctl0_reg <= SCU_CTL0_RST;
			ctl1_reg <= SCU_CTL1_RST;
			brg_reg <= SCU_BRG_RST;
			rsp_reg <= '0;
			txbuf_reg <= 8'h00;
			rxbuf_reg <= 8'h00;
			ovr_reg <= 1'b0;
			fe_reg <= 1'b0;
			pe_reg <= 1'b0;
			tx_req_reg <= 1'b0;
			rx_req_reg <= 1'b0;
			lvl_reg <= 1'b1;
			tx_state_reg <= TX_IDLE;
			rx_state_reg <= RX_IDLE;
			tx_cnt_reg <= 4'h0;
			rx_cnt_reg <= 4'h0;
			tx_bit_reg <= 3'h0;
			rx_bit_reg <= 3'h0;
			tx_sh_reg <= 8'h00;
			rx_sh_reg <= 8'h00;
			tx_par_reg <= 1'b0;
			rx_par_reg <= 1'b0;
			rx_pe_reg <= 1'b0;
			rx_phase_reg <= 1'b0;
			out_reg <= 1'b1;
			oe_reg <= 1'b1;
		end else begin
			mode_reg <= mode_next;
			ctl0_reg <= ctl0_next;
			ctl1_reg <= ctl1_next;
			brg_reg <= brg_next;
			rsp_reg <= rsp_next;
			txbuf_reg <= txbuf_next;
			rxbuf_reg <= rxbuf_next;
			ovr_reg <= ovr_next;
			fe_reg <= fe_next;
			pe_reg <= pe_next;
			tx_req_reg <= tx_req_next;
			rx_req_reg <= rx_req_next;
			lvl_reg <= lvl_next;
			tx_state_reg <= tx_state_next;
			rx_state_reg <= rx_state_next;
			tx_cnt_reg <= tx_cnt_next;
			rx_cnt_reg <= rx_cnt_next;
			tx_bit_reg <= tx_bit_next;
			rx_bit_reg <= rx_bit_next;
			tx_sh_reg <= tx_sh_next;
			rx_sh_reg <= rx_sh_next;
			tx_par_reg <= tx_par_next;
			rx_par_reg <= rx_par_next;
			rx_pe_reg <= rx_pe_next;
			rx_phase_reg <= rx_phase_next;
			out_reg <= out_next;
			oe_reg <= oe_next;
		end
	end

	default clocking cb @(posedge clock); endclocking
	default disable iff (sys_rst);

	a_tx_start_gate: assert property (tx_state_reg == TX_IDLE
		&& tx_state_next == TX_START |-> ctl1_reg.te && !ctl1_reg.tx_empty && card_ok)
		else $error("transmit started without enable or data");
	a_rx_start_gate: assert property (rx_state_reg == RX_IDLE
		##1 rx_state_reg == RX_START |-> $past(ctl1_reg.re) && !$past(serial_in_pin))
		else $error("receive started without enable or start bit");
	a_sleep_zero: assert property (mode_reg.sleep == 1'b0)
		else $error("sleep bit became set");
	a_ovr_no_req: assert property (rx_done && ctl1_reg.rx_full && !rx_req_reg
		&& !done |=> !rx_req_reg && ovr_reg)
		else $error("overrun raised a receive request");
	a_rx_load_req: assert property (rx_done && !ctl1_reg.rx_full |=> rx_req_reg && ctl1_reg.rx_full)
		else $error("receive request missing after load");
	a_err_low_out: assert property (rx_state_reg == RX_ERRSIG && rx_phase_reg
		|=> oe_reg && !out_reg)
		else $error("error signal not driven low");
	a_brg_period: assert property (ovs_reg && !mode_reg.ext_clk
		&& ctl0_reg.clk_sel == SCU_SEL_F1 && brg_reg == 8'h00 && $stable(brg_reg) |=> ovs_reg)
		else $error("bit rate tick spacing wrong");
	a_guard_irq: assert property (tx_state_reg == TX_GUARD && ovs_reg
		&& tx_cnt_reg == SCU_OVS_MID && ctl1_reg.irq_done
		|=> tx_req_reg && lvl_reg == $past(serial_in_pin))
		else $error("transmit request missing at error check");
	a_start_low: assert property (tx_state_reg == TX_START
		&& !(rx_state_reg == RX_ERRSIG) |=> oe_reg && !out_reg)
		else $error("start bit not low");

	c_tx_frame: cover property (tx_state_reg == TX_STOP ##1 tx_state_reg == TX_IDLE);
	c_rx_parity_err: cover property (rx_state_reg == RX_ERRSIG && rx_phase_reg);
	c_overrun: cover property (rx_done && ctl1_reg.rx_full);
	c_guard: cover property (tx_state_reg == TX_GUARD);
endmodule : scu_sim_uart

/* File: test/scu_card_model.sv */
`timescale 1ns/1ps
module scu_card_model (
	// Clock
	input wire logic clock,
	// Shared line
	input wire logic line,
	output logic drive_low,
	// Controls from the bench, and the sending flag back to it
	input wire logic inverse,
	input wire logic [15:0] bit_cyc,
	input wire logic force_nack,
	input wire logic bad_par,
	input wire logic send_req,
	input wire logic [7:0] send_byte,
	output logic sending,
	// Last character heard
	output logic [7:0] rx_byte,
	output logic [7:0] rx_cnt,
	output logic rx_par_ok
);
	logic nack_low = 1'b0;
	logic tx_low = 1'b0;
	assign drive_low = nack_low | tx_low;
	// Works both ways: direct is plain LSB first, inverse is inverted MSB first
	function automatic logic [7:0] swap(input logic [7:0] d, input logic inv);
		for (int i = 0; i < 8; i++) begin
			swap[i] = inv ? ~d[7 - i] : d[i];
		end
	endfunction : swap
	initial begin : rx_side
		logic [7:0] lb;
		logic p;
		rx_byte = 8'h00;
		rx_cnt = 8'h00;
		rx_par_ok = 1'b0;
		forever begin
			@(posedge clock);
			if (line === 1'b0 && sending !== 1'b1) begin
				repeat (bit_cyc / 2) @(posedge clock);
				for (int i = 0; i < 8; i++) begin
					repeat (bit_cyc) @(posedge clock);
					lb[i] = line;
				end
				repeat (bit_cyc) @(posedge clock);
				p = line;
				rx_byte = swap(lb, inverse);
				rx_par_ok = (p === (inverse ? ~^lb : ^lb));
				rx_cnt++;
				repeat (bit_cyc + bit_cyc / 2) @(posedge clock);
				// Pull low for one bit after the stop bit
				if (!rx_par_ok || force_nack) begin
					nack_low <= 1'b1;
					repeat (bit_cyc) @(posedge clock);
					nack_low <= 1'b0;
				end
			end
		end
	end
	initial begin : tx_side
		logic [7:0] lb;
		sending = 1'b0;
		forever begin
			@(posedge clock);
			if (send_req === 1'b1) begin
				lb = swap(send_byte, inverse);
				sending <= 1'b1;
				tx_low <= 1'b1;
				repeat (bit_cyc) @(posedge clock);
				for (int i = 0; i < 8; i++) begin
					tx_low <= ~lb[i];
					repeat (bit_cyc) @(posedge clock);
				end
				tx_low <= ~((inverse ? ~^lb : ^lb) ^ bad_par);
				repeat (bit_cyc) @(posedge clock);
				tx_low <= 1'b0;
				// Deaf while the device may answer with its error signal
				repeat (3 * bit_cyc) @(posedge clock);
				sending <= 1'b0;
			end
		end
	end
endmodule : scu_card_model

/* File: test/uart_smart_card_sim_mode_tb.sv */
`timescale 1ns/1ps
module uart_smart_card_sim_mode_tb;
	import scu_pkg::*;
	typedef struct packed {
		logic [7:0] mode;
		logic [7:0] ctl0;
		logic [7:0] ctl1;
		logic [7:0] brg;
		logic [7:0] data;
		logic inv;
		logic [15:0] bits;
	} scu_row_t;
	logic clock;
	logic sys_rst;
	scu_apb_req_t req;
	scu_apb_rsp_t rsp;
	logic ext_clk;
	logic cts_n;
	logic serial_out_pin;
	logic serial_out_oe;
	logic card_low;
	logic line;
	logic dev_low;
	logic inverse;
	logic [15:0] bit_cyc;
	logic force_nack;
	logic bad_par;
	logic send_req;
	logic [7:0] send_byte;
	logic sending;
	logic [7:0] rx_byte;
	logic [7:0] rx_cnt;
	logic rx_par_ok;
	logic [31:0] rdata;
	logic rerr;
	logic [15:0] run;
	logic [15:0] run2;
	logic [7:0] n0;
	int nrun;
	int nlow;
	int miscompares;
	int n_checks;
	scu_row_t rows [6] = '{
		'{8'h65, 8'h30, 8'h11, 8'h00, 8'h35, 1'b0, 16'h10},
		'{8'h45, 8'hb0, 8'h51, 8'h00, 8'h4a, 1'b1, 16'h10},
		'{8'h65, 8'h30, 8'h11, 8'h02, 8'h35, 1'b0, 16'h30},
		'{8'h45, 8'hb1, 8'h51, 8'h00, 8'h4a, 1'b1, 16'h80},
		'{8'h65, 8'h32, 8'h11, 8'h00, 8'h35, 1'b0, 16'h200},
		'{8'h6d, 8'h30, 8'h11, 8'h00, 8'h35, 1'b0, 16'h20}};
	logic [7:0] rst_v [4] = '{SCU_MODE_RST, SCU_CTL0_RST, SCU_CTL1_RST, SCU_BRG_RST};
	// Open-drain wire with pull-up
	assign dev_low = serial_out_oe && !serial_out_pin;
	assign line = !(dev_low || card_low);
	scu_sim_uart i_scu_sim_uart (
		.clock(clock), .sys_rst(sys_rst), .apb_req(req), .apb_rsp(rsp),
		.serial_in_pin(line), .channel_clock_pin(ext_clk), .cts_in_n(cts_n),
		.serial_out_pin(serial_out_pin), .serial_out_oe(serial_out_oe));
	scu_card_model i_scu_card_model (
		.clock(clock), .line(line), .drive_low(card_low), .inverse(inverse),
		.bit_cyc(bit_cyc), .force_nack(force_nack), .bad_par(bad_par),
		.send_req(send_req), .send_byte(send_byte), .sending(sending),
		.rx_byte(rx_byte), .rx_cnt(rx_cnt), .rx_par_ok(rx_par_ok));
	initial begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end
	// External baud source: one rising edge every two clocks
	always @(posedge clock) begin
		ext_clk <= ~ext_clk;
	end
	// Lengths of low runs driven by the device
	always @(posedge clock) begin
		if (dev_low) begin
			run <= run + 16'h1;
			nlow <= nlow + 1;
		end else if (run != 16'h0) begin
			if (nrun == 1) run2 <= run;
			nrun <= nrun + 1;
			run <= 16'h0;
		end
	end
	task automatic complete_run();
		$display("checks %0d miscompares %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : complete_run
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			miscompares++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		k = 0;
		@(posedge clock);
		req <= '{1'b1, 1'b0, w, a, d};
		@(posedge clock);
		req.penable <= 1'b1;
		// The answer is read as sampled at each rising edge, before that edge moves it
		do begin
			@(posedge clock);
			k++;
		end while (rsp.pready !== 1'b1 && k < 50);
		if (k >= 50) begin
			miscompares++;
			complete_run();
		end
		rdata = rsp.prdata;
		rerr = rsp.pslverr;
		req <= '0;
	endtask : apb
	task automatic poll(input logic [31:0] m);
		int k;
		k = 0;
		do begin
			apb(1'b0, SCU_STAT_OFF, 32'h0);
			k++;
		end while ((rdata & m) == 32'h0 && k < 3000);
		if (k >= 3000) begin
			miscompares++;
			complete_run();
		end
	endtask : poll
	task automatic wait_card(input logic [7:0] c);
		int k;
		k = 0;
		do begin
			@(posedge clock);
			k++;
		end while (rx_cnt == c && k < 20 * bit_cyc);
		if (rx_cnt == c) begin
			miscompares++;
			complete_run();
		end
	endtask : wait_card
	task automatic send_card(input logic [7:0] b);
		int k;
		k = 0;
		send_byte <= b;
		send_req <= 1'b1;
		@(posedge clock);
		send_req <= 1'b0;
		do begin
			@(posedge clock);
			k++;
		end while (sending === 1'b1 && k < 20 * bit_cyc);
		if (k >= 20 * bit_cyc) begin
			miscompares++;
			complete_run();
		end
	endtask : send_card
	initial begin
		sys_rst = 1'b1;
		req = '0;
		ext_clk = 1'b0;
		cts_n = 1'b1;
		inverse = 1'b0;
		bit_cyc = 16'h10;
		force_nack = 1'b0;
		bad_par = 1'b0;
		send_req = 1'b0;
		send_byte = 8'h00;
		run = 16'h0;
		run2 = 16'h0;
		nrun = 0;
		nlow = 0;
		miscompares = 0;
		n_checks = 0;
		repeat (6) @(posedge clock);
		sys_rst <= 1'b0;
		for (int i = 0; i < 4; i++) begin
			apb(1'b0, 8'(4 * i), 32'h0);
			chk("reset value", {24'h0, rst_v[i]}, rdata);
		end
		apb(1'b0, 8'h1c, 32'h0);
		chk("unmapped error", 32'h1, {31'h0, rerr});
		chk("unmapped data", 32'h0, rdata);
		apb(1'b1, SCU_MODE_OFF, 32'he5);
		apb(1'b0, SCU_MODE_OFF, 32'h0);
		chk("sleep bit", 32'h65, rdata);
		foreach (rows[r]) begin
			apb(1'b1, SCU_MODE_OFF, {24'h0, rows[r].mode});
			apb(1'b1, SCU_CTL0_OFF, {24'h0, rows[r].ctl0});
			apb(1'b1, SCU_BRG_OFF, {24'h0, rows[r].brg});
			apb(1'b1, SCU_CTL1_OFF, {24'h0, rows[r].ctl1});
			inverse <= rows[r].inv;
			bit_cyc <= rows[r].bits;
			nrun <= 0;
			n0 = rx_cnt;
			apb(1'b1, SCU_TXB_OFF, {24'h0, rows[r].data});
			wait_card(n0);
			chk("card byte", {24'h0, rows[r].data}, {24'h0, rx_byte});
			chk("card parity", 32'h1, {31'h0, rx_par_ok});
			chk("bit time", {16'h0, rows[r].bits}, {16'h0, run2});
			poll(32'h1);
			chk("tx request", 32'h5, rdata & 32'h7);
			apb(1'b1, SCU_STAT_OFF, 32'h3);
			apb(1'b1, SCU_CTL1_OFF, {24'h0, rows[r].ctl1 | 8'h04});
			send_card(rows[r].data);
			apb(1'b0, SCU_STAT_OFF, 32'h0);
			chk("rx request", 32'h2, rdata & 32'h3);
			apb(1'b0, SCU_RXB_OFF, 32'h0);
			chk("rx data", {24'h0, rows[r].data}, rdata);
			apb(1'b1, SCU_CTL1_OFF, {24'h0, rows[r].ctl1});
			apb(1'b1, SCU_STAT_OFF, 32'h3);
		end
		// A frame must wait for a legal mode and clear-to-send, then go out unaided
		bit_cyc <= 16'h10;
		inverse <= 1'b0;
		n0 = rx_cnt;
		apb(1'b1, SCU_MODE_OFF, 32'h75);
		apb(1'b1, SCU_CTL0_OFF, 32'h20);
		apb(1'b1, SCU_CTL1_OFF, 32'h01);
		apb(1'b1, SCU_TXB_OFF, 32'h35);
		for (int i = 0; i < 3; i++) begin
			apb(1'b1, SCU_MODE_OFF, i == 0 ? 32'h75 : (i == 1 ? 32'h64 : 32'h65));
			repeat (64) @(posedge clock);
			apb(1'b0, SCU_STAT_OFF, 32'h0);
			chk("idle", 32'h0, rdata & 32'h9);
			chk("no frame", {24'h0, n0}, {24'h0, rx_cnt});
		end
		cts_n <= 1'b0;
		poll(32'h8);
		chk("early request", 32'h1, rdata & 32'h1);
		wait_card(n0);
		chk("held byte", 32'h35, {24'h0, rx_byte});
		poll(32'h1);
		apb(1'b1, SCU_STAT_OFF, 32'h3);
		// Card complains: request moves to the guard bit, line seen low
		apb(1'b1, SCU_CTL1_OFF, 32'h91);
		force_nack <= 1'b1;
		n0 = rx_cnt;
		apb(1'b1, SCU_TXB_OFF, 32'h35);
		wait_card(n0);
		poll(32'h1);
		chk("error capture", 32'h1, rdata & 32'h5);
		force_nack <= 1'b0;
		apb(1'b1, SCU_STAT_OFF, 32'h3);
		// Overrun
		apb(1'b1, SCU_CTL1_OFF, 32'h95);
		send_card(8'h35);
		apb(1'b1, SCU_STAT_OFF, 32'h3);
		send_card(8'h4a);
		apb(1'b0, SCU_STAT_OFF, 32'h0);
		chk("overrun request", 32'h0, rdata & 32'h2);
		apb(1'b0, SCU_RXB_OFF, 32'h0);
		chk("overrun data", 32'h904a, rdata);
		apb(1'b0, SCU_RXB_OFF, 32'h0);
		chk("after read", 32'h4a, rdata);
		// Bad parity from the card draws the error signal
		nlow <= 0;
		bad_par <= 1'b1;
		send_card(8'h35);
		chk("error signal", 32'h10, nlow);
		apb(1'b0, SCU_RXB_OFF, 32'h0);
		chk("parity error", 32'hc035, rdata);
		bad_par <= 1'b0;
		// Reset in mid-frame: line driven high, engine and control register back to reset values
		apb(1'b1, SCU_TXB_OFF, 32'h35);
		repeat (40) @(posedge clock);
		sys_rst <= 1'b1;
		repeat (6) @(posedge clock);
		sys_rst <= 1'b0;
		@(posedge clock);
		chk("reset line", 32'h3, {30'h0, serial_out_pin, serial_out_oe});
		apb(1'b0, SCU_STAT_OFF, 32'h0);
		chk("reset status", 32'h0, rdata & 32'hb);
		apb(1'b0, SCU_CTL1_OFF, 32'h0);
		chk("reset control", {24'h0, SCU_CTL1_RST}, rdata);
		complete_run();
	end
endmodule : uart_smart_card_sim_mode_tb
